// *** core/dtg_pkg.sv ***
package dtg_pkg;

   // Register offsets on the plain register port.
   localparam logic [7:0] A_STAT  = 8'h86;
   localparam logic [7:0] A_MASK  = 8'h87;
   localparam logic [7:0] A_CTRL  = 8'h88;
   localparam logic [7:0] A_CFG   = 8'h89;
   localparam logic [7:0] A_TL0   = 8'h8a;
   localparam logic [7:0] A_TL1   = 8'h8b;
   localparam logic [7:0] A_TH0   = 8'h8c;
   localparam logic [7:0] A_TH1   = 8'h8d;
   localparam logic [7:0] A_PRESC = 8'h8e;

   // Field positions of the mode configuration register.
   localparam int CFG_TIMER1_GATE_SEL = 7;
   localparam int CFG_M1_LO = 4;
   localparam int CFG_TIMER0_GATE_SEL = 3;
   localparam int CFG_M0_LO = 0;
   localparam logic [7:0] CFG_WMASK = 8'hbb;

   // Field positions of the run control and flag registers.
   localparam int CTRL_RUN1 = 6;
   localparam int CTRL_RUN0 = 4;
   localparam int FLAG_T0   = 0;
   localparam int FLAG_T1   = 1;

   // Timer operating modes.
   localparam logic [1:0] MODE_13B   = 2'h0;
   localparam logic [1:0] MODE_16B   = 2'h1;
   localparam logic [1:0] MODE_8AR   = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;

   // Prescaler selector codes and division ratios in system clocks.
   localparam logic [1:0] PSC_DIV12 = 2'h0;
   localparam logic [1:0] PSC_DIV4  = 2'h1;
   localparam logic [1:0] PSC_DIV48 = 2'h2;
   localparam logic [5:0] DIV12     = 6'h0c;
   localparam logic [5:0] DIV4      = 6'h04;
   localparam logic [5:0] DIV48     = 6'h30;
   localparam logic [5:0] DIV_OTHER = 6'h08;

   // Complete state of the control block.
   typedef struct packed {
      logic [7:0] cfg;
      logic       run0;
      logic       run1;
      logic [1:0] flag;
      logic [1:0] mask;
      logic [1:0] presc;
      logic [7:0] tl0;
      logic [7:0] th0;
      logic [7:0] tl1;
      logic [7:0] th1;
      logic [5:0] div;
      logic [1:0] sy0;
      logic [1:0] sy1;
      logic       act1;
      logic [7:0] rdata;
   } dtg_state_t;

   // Every field comes out of reset as zero, except the pin synchronisers.
   // They start at the idle high level, so no gate sees a false active pin after reset.
   localparam dtg_state_t ST_RST = '{sy0: 2'h3, sy1: 2'h3, default: '0};

endpackage

// *** core/dtg_cnt_if.sv ***
`timescale 1ns/1ps
// One timer's byte pair, its mode and enable, and the counted result.
interface dtg_cnt_if;
   import dtg_pkg::*;
   logic [1:0] mode;
   logic       en;
   logic [7:0] tl;
   logic [7:0] th;
   logic [7:0] tl_nxt;
   logic [7:0] th_nxt;
   logic       ovf;
   modport ctl (output mode, en, tl, th, input tl_nxt, th_nxt, ovf);
   modport cnt (input mode, en, tl, th, output tl_nxt, th_nxt, ovf);
endinterface

// *** core/dtg_cnt.sv ***
`timescale 1ns/1ps
module dtg_cnt
   import dtg_pkg::*;
(
   // Counter operands and result.
   dtg_cnt_if.cnt c
);

   // Next count of one timer; the split high byte is handled by the caller.
   always_comb begin
      c.tl_nxt = c.tl;
      c.th_nxt = c.th;
      c.ovf    = 1'b0;
      if (c.en) begin
         unique case (c.mode)
            MODE_13B: begin
               // The top three low bits are left alone, as a prescaler of five bits.
               c.tl_nxt = {c.tl[7:5], c.tl[4:0] + 5'h01};
               if (c.tl[4:0] == 5'h1f) begin
                  c.th_nxt = c.th + 8'h01;
                  c.ovf    = (c.th == 8'hff);
               end
            end
            MODE_16B: begin
               c.tl_nxt = c.tl + 8'h01;
               if (c.tl == 8'hff) begin
                  c.th_nxt = c.th + 8'h01;
                  c.ovf    = (c.th == 8'hff);
               end
            end
            MODE_8AR: begin
               if (c.tl == 8'hff) begin
                  c.tl_nxt = c.th;
                  c.ovf    = 1'b1;
               end else begin
                  c.tl_nxt = c.tl + 8'h01;
               end
            end
            MODE_SPLIT: begin
               c.tl_nxt = c.tl + 8'h01;
               c.ovf    = (c.tl == 8'hff);
            end
         endcase
      end
   end

endmodule

// *** core/dtg_top.sv ***
// Our own choice: strobed register access.
`timescale 1ns/1ps
module dtg_top
   import dtg_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       nrst,
   // Register port.
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // External interrupt pins, active low, asynchronous.
   input  wire logic       ext_irq0_n,
   input  wire logic       ext_irq1_n,
   // System events.
   input  wire logic       osc_resume,
   input  wire logic       isr_ack0,
   input  wire logic       isr_ack1,
   // Outputs to the interrupt controller.
   output logic            irq,
   output logic            timer0_overflow_flag,
   output logic            timer1_overflow_flag,
   output logic            ext_irq1_active
);

   dtg_state_t s_r;
   dtg_state_t s;
   logic       timer0_gate_sel;
   logic       timer1_gate_sel;
   logic [1:0] m0;
   logic [1:0] m1;
   logic       ext0_on;
   logic       ext1_on;
   logic       tick;
   logic [5:0] lim;
   logic       hi_ovf;
   logic [1:0] setf;
   logic [1:0] clrf;

   dtg_cnt_if t0 ();
   dtg_cnt_if t1 ();

   dtg_cnt u_t0 (.c(t0));
   dtg_cnt u_t1 (.c(t1));

   // Decoded configuration and synchronised pin levels.
   assign timer0_gate_sel   = s_r.cfg[CFG_TIMER0_GATE_SEL];
   assign timer1_gate_sel   = s_r.cfg[CFG_TIMER1_GATE_SEL];
   assign m0      = s_r.cfg[CFG_M0_LO +: 2];
   assign m1      = s_r.cfg[CFG_M1_LO +: 2];
   assign ext0_on = ~s_r.sy0[1];
   assign ext1_on = ~s_r.sy1[1];

   // Prescaler limit; a selector change takes effect at the next wrap or at once if passed.
   always_comb begin
      unique case (s_r.presc)
         PSC_DIV12: lim = DIV12;
         PSC_DIV4:  lim = DIV4;
         PSC_DIV48: lim = DIV48;
         default:   lim = DIV_OTHER;
      endcase
   end
   assign tick = (s_r.div >= lim - 6'h01);

   // Gated enables; timer 1 in mode 3 never receives a tick.
   assign t0.mode = m0;
   assign t0.en   = tick & s_r.run0 & (~timer0_gate_sel | ext0_on);
   assign t0.tl   = s_r.tl0;
   assign t0.th   = s_r.th0;
   assign t1.mode = m1;
   assign t1.en   = tick & s_r.run1 & (~timer1_gate_sel | ext1_on) & (m1 != MODE_SPLIT);
   assign t1.tl   = s_r.tl1;
   assign t1.th   = s_r.th1;

   // Split mode borrows timer 1's run bit and flag for the high byte of timer 0.
   assign hi_ovf = (m0 == MODE_SPLIT) & tick & s_r.run1 & (s_r.th0 == 8'hff);
   assign setf[FLAG_T0] = t0.ovf;
   assign setf[FLAG_T1] = (m0 == MODE_SPLIT) ? hi_ovf : t1.ovf;

   // Flag clears from software and from vectoring.
   assign clrf = ((wr && addr == A_STAT) ? wdata[1:0] : 2'h0) | {isr_ack1, isr_ack0};

   // Next state: counting first, then register writes, which take priority over the counted timer bytes.
   always_comb begin
      s       = s_r;
      s.sy0   = {s_r.sy0[0], ext_irq0_n};
      s.sy1   = {s_r.sy1[0], ext_irq1_n};
      s.act1  = ext1_on | (~timer1_gate_sel & osc_resume);
      s.div   = tick ? 6'h00 : s_r.div + 6'h01;
      s.tl0   = t0.tl_nxt;
      s.th0   = t0.th_nxt;
      if (m0 == MODE_SPLIT && tick && s_r.run1) begin
         s.th0 = s_r.th0 + 8'h01;
      end
      s.tl1   = t1.tl_nxt;
      s.th1   = t1.th_nxt;
      // A new overflow beats a clear in the same cycle.
      s.flag  = (s_r.flag & ~clrf) | setf;
      s.rdata = 8'h00;
      if (wr) begin
         unique case (addr)
            A_MASK:  s.mask  = wdata[1:0];
            A_CTRL: begin
               s.run0 = wdata[CTRL_RUN0];
               s.run1 = wdata[CTRL_RUN1];
            end
            A_CFG:   s.cfg   = wdata & CFG_WMASK;
            A_TL0:   s.tl0   = wdata;
            A_TL1:   s.tl1   = wdata;
            A_TH0:   s.th0   = wdata;
            A_TH1:   s.th1   = wdata;
            A_PRESC: s.presc = wdata[1:0];
            default: ;
         endcase
      end
      if (rd) begin
         unique case (addr)
            A_STAT:  s.rdata = {6'h00, s_r.flag};
            A_MASK:  s.rdata = {6'h00, s_r.mask};
            A_CTRL:  s.rdata = {1'b0, s_r.run1, 1'b0, s_r.run0, 4'h0};
            A_CFG:   s.rdata = s_r.cfg;
            A_TL0:   s.rdata = s_r.tl0;
            A_TL1:   s.rdata = s_r.tl1;
            A_TH0:   s.rdata = s_r.th0;
            A_TH1:   s.rdata = s_r.th1;
            A_PRESC: s.rdata = {6'h00, s_r.presc};
            default: s.rdata = 8'h00;
         endcase
      end
   end

   // State register.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s;
      end
   end

   // Outputs come straight from the state; the interrupt is a masked level.
   assign rdata                = s_r.rdata;
   assign timer0_overflow_flag = s_r.flag[FLAG_T0];
   assign timer1_overflow_flag = s_r.flag[FLAG_T1];
   assign ext_irq1_active      = s_r.act1;
   assign irq                  = |(s_r.flag & s_r.mask);

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence div4_hold;
      (s_r.presc == PSC_DIV4) [*4];
   endsequence

   sequence t1_frozen;
      $stable(s_r.tl1) && $stable(s_r.th1);
   endsequence

   timer1_gate_sel_off_count_a: assert property (
      (tick && s_r.run1 && !timer1_gate_sel && m1 == MODE_16B && !wr)
      |=> (s_r.tl1 == $past(s_r.tl1) + 8'h01))
      else $error("Timer 1 did not count with gate off.");

   resume_wake_a: assert property (
      (osc_resume && !timer1_gate_sel) |=> ext_irq1_active)
      else $error("Resume did not activate interrupt 1.");

   timer1_gate_sel_block_a: assert property (
      (timer1_gate_sel && !ext1_on && !wr) |=> t1_frozen)
      else $error("Timer 1 counted with pin inactive.");

   mode13_carry_a: assert property (
      (t0.en && m0 == MODE_13B && s_r.tl0[4:0] == 5'h1f && !wr)
      |=> (s_r.tl0[4:0] == 5'h00) && (s_r.th0 == $past(s_r.th0) + 8'h01))
      else $error("13-bit carry wrong.");

   reload_8bit_a: assert property (
      (t0.en && m0 == MODE_8AR && s_r.tl0 == 8'hff && !wr)
      |=> (s_r.tl0 == $past(s_r.th0)) && s_r.flag[FLAG_T0])
      else $error("Auto reload failed.");

   t1_mode3_hold_a: assert property (
      (m1 == MODE_SPLIT && !wr) |=> t1_frozen)
      else $error("Timer 1 moved in mode 3.");

   timer0_gate_sel_block_a: assert property (
      (timer0_gate_sel && !ext0_on && !wr) |=> $stable(s_r.tl0))
      else $error("Timer 0 counted with pin inactive.");

   ovf_flag_set_a: assert property (
      t0.ovf |=> s_r.flag[FLAG_T0]
         && (irq == (s_r.mask[FLAG_T0] | (s_r.flag[FLAG_T1] & s_r.mask[FLAG_T1]))))
      else $error("Overflow flag not set.");

   ack_clear_a: assert property (
      (isr_ack1 && !setf[FLAG_T1]) |=> !timer1_overflow_flag)
      else $error("Vectoring did not clear flag.");

   ack0_clear_a: assert property (
      (isr_ack0 && !setf[FLAG_T0]) |=> !timer0_overflow_flag)
      else $error("Vectoring did not clear flag 0.");

   w1c_clear_a: assert property (
      (wr && addr == A_STAT && wdata[FLAG_T1] && !setf[FLAG_T1]) |=> !timer1_overflow_flag)
      else $error("Writing one did not clear flag 1.");

   flag1_set_a: assert property (
      setf[FLAG_T1] |=> timer1_overflow_flag)
      else $error("Overflow flag 1 not set.");

   split_hi_count_a: assert property (
      (m0 == MODE_SPLIT && tick && s_r.run1 && !wr)
      |=> (s_r.th0 == $past(s_r.th0) + 8'h01))
      else $error("Split high byte did not count.");

   timer0_gate_sel_on_count_a: assert property (
      (tick && s_r.run0 && timer0_gate_sel && ext0_on && m0 == MODE_16B && !wr)
      |=> (s_r.tl0 == $past(s_r.tl0) + 8'h01))
      else $error("Timer 0 did not count with pin active.");

   // The spacing is judged only while the selector stays put, since a new code changes the limit without clearing the divider.
   prescale_div4_a: assert property (
      (tick && s_r.presc == PSC_DIV4) ##1 div4_hold
      |-> tick && !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3))
      else $error("Divide by 4 tick spacing wrong.");

endmodule

// *** test/dtg_top_tb.sv ***
`timescale 1ns/1ps
module dtg_top_tb;
   import dtg_pkg::*;

   // Bench drivers and design outputs.
   logic       clk = 1'b0;
   logic       nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   logic       ext_irq0_n = 1'b1;
   logic       ext_irq1_n = 1'b1;
   logic       osc_resume = 1'b0;
   logic       isr_ack0 = 1'b0;
   logic       isr_ack1 = 1'b0;
   logic       irq;
   logic       timer0_overflow_flag;
   logic       timer1_overflow_flag;
   logic       ext_irq1_active;
   int         err_count = 0;
   int         num_checks = 0;
   int         cycles = 0;
   logic [5:0] divs [4] = '{DIV12, DIV4, DIV48, DIV_OTHER};

   dtg_top uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .ext_irq0_n(ext_irq0_n), .ext_irq1_n(ext_irq1_n),
      .osc_resume(osc_resume), .isr_ack0(isr_ack0), .isr_ack1(isr_ack1), .irq(irq),
      .timer0_overflow_flag(timer0_overflow_flag),
      .timer1_overflow_flag(timer1_overflow_flag), .ext_irq1_active(ext_irq1_active));

   // Clock at 40 MHz.
   initial forever #12.5 clk = ~clk;

   // A hang is cut short well after the whole sequence should be over.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         test_done();
      end
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // One-cycle write strobe beside address and data.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
         err_count++;
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      chk8({7'h00, got}, {7'h00, exp}, what);
   endtask

   // Read data are looked at just after the edge that follows the strobe.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk8(rdata, exp, what);
   endtask

   // Run bits stay set for exactly 96 cycles, a multiple of every divider ratio,
   // so the free-running tick phase cannot change the count.
   task automatic measure(input logic [7:0] run, input logic [7:0] a, input logic [7:0] exp);
      wr_reg(A_CTRL, 8'h00);
      wr_reg(a, 8'h00);
      wr_reg(A_CTRL, run);
      repeat (94) @(posedge clk);
      wr_reg(A_CTRL, 8'h00);
      rd_chk(a, exp, "count after window");
   endtask

   // Bounded wait for one overflow flag.
   task automatic wait_flag(input int i);
      int k;
      for (k = 0; k < 300; k++) begin
         @(posedge clk);
         #1;
         if (((i == 0) ? timer0_overflow_flag : timer1_overflow_flag) === 1'b1) break;
      end
   endtask

   // Main sequence.
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(A_CFG, 8'h00, "config reset");
      wr_reg(A_CFG, 8'hff);
      rd_chk(A_CFG, CFG_WMASK, "reserved bits");
      @(posedge clk);
      #1;
      chk8(rdata, 8'h00, "read data drops");
      wr_reg(8'h80, 8'h5a);
      rd_chk(8'h80, 8'h00, "unmapped read");
      wr_reg(A_CFG, 8'h01);
      for (int i = 0; i < 4; i++) begin
         wr_reg(A_PRESC, 8'(i));
         measure(8'h10, A_TL0, 8'(96 / int'(divs[i])));
      end
      wr_reg(A_PRESC, 8'h00);
      // Timer 0 gating: pin high blocks, pin low lets it count.
      wr_reg(A_CFG, 8'h09);
      measure(8'h10, A_TL0, 8'h00);
      ext_irq0_n <= 1'b0;
      measure(8'h10, A_TL0, 8'h08);
      ext_irq0_n <= 1'b1;
      wr_reg(A_CFG, 8'h01);
      measure(8'h10, A_TL0, 8'h08);
      // Timer 1 gating in the same way.
      wr_reg(A_CFG, 8'h10);
      measure(8'h40, A_TL1, 8'h08);
      wr_reg(A_CFG, 8'h90);
      measure(8'h40, A_TL1, 8'h00);
      ext_irq1_n <= 1'b0;
      measure(8'h40, A_TL1, 8'h08);
      ext_irq1_n <= 1'b1;
      // Split mode: timer 1 stands still, high byte of timer 0 uses run 1.
      wr_reg(A_CFG, 8'h33);
      measure(8'h40, A_TL1, 8'h00);
      measure(8'h40, A_TH0, 8'h08);
      // 16-bit overflow of both timers, flags and the masked interrupt.
      wr_reg(A_CFG, 8'h11);
      wr_reg(A_MASK, 8'h01);
      wr_reg(A_TH0, 8'hff);
      wr_reg(A_TL0, 8'hff);
      wr_reg(A_CTRL, 8'h10);
      wait_flag(0);
      chk1(timer0_overflow_flag, 1'b1, "flag 0 set");
      chk1(irq, 1'b1, "unmasked irq");
      wr_reg(A_CTRL, 8'h00);
      rd_chk(A_TH0, 8'h00, "16-bit wrap");
      @(posedge clk);
      isr_ack0 <= 1'b1;
      @(posedge clk);
      isr_ack0 <= 1'b0;
      #1;
      chk1(timer0_overflow_flag, 1'b0, "ack clears flag 0");
      chk1(irq, 1'b0, "irq drops");
      wr_reg(A_TH1, 8'hff);
      wr_reg(A_TL1, 8'hff);
      wr_reg(A_CTRL, 8'h40);
      wait_flag(1);
      wr_reg(A_CTRL, 8'h00);
      chk1(irq, 1'b0, "masked irq");
      rd_chk(A_STAT, 8'h02, "status flag 1");
      wr_reg(A_STAT, 8'h02);
      #1;
      chk1(timer1_overflow_flag, 1'b0, "write one clears");
      // Second timer 1 overflow, this time cleared by vectoring.
      wr_reg(A_TH1, 8'hff);
      wr_reg(A_TL1, 8'hff);
      wr_reg(A_CTRL, 8'h40);
      wait_flag(1);
      wr_reg(A_CTRL, 8'h00);
      chk1(timer1_overflow_flag, 1'b1, "flag 1 set again");
      @(posedge clk);
      isr_ack1 <= 1'b1;
      @(posedge clk);
      isr_ack1 <= 1'b0;
      #1;
      chk1(timer1_overflow_flag, 1'b0, "ack clears flag 1");
      // Auto-reload from the high byte.
      wr_reg(A_CFG, 8'h02);
      wr_reg(A_TH0, 8'h50);
      wr_reg(A_TL0, 8'hff);
      wr_reg(A_CTRL, 8'h10);
      wait_flag(0);
      wr_reg(A_CTRL, 8'h00);
      chk1(timer0_overflow_flag, 1'b1, "reload overflow");
      rd_chk(A_TL0, 8'h50, "reloaded low byte");
      rd_chk(A_TH0, 8'h50, "high byte kept");
      // 13-bit overflow at low five bits all ones.
      wr_reg(A_STAT, 8'h03);
      wr_reg(A_CFG, 8'h00);
      wr_reg(A_TH0, 8'hff);
      wr_reg(A_TL0, 8'h1f);
      wr_reg(A_CTRL, 8'h10);
      wait_flag(0);
      wr_reg(A_CTRL, 8'h00);
      chk1(timer0_overflow_flag, 1'b1, "13-bit overflow");
      rd_chk(A_TL0, 8'h00, "13-bit low wrap");
      // Oscillator resume raises interrupt 1 only with gate 1 off.
      @(posedge clk);
      osc_resume <= 1'b1;
      @(posedge clk);
      osc_resume <= 1'b0;
      #1;
      chk1(ext_irq1_active, 1'b1, "resume, gate off");
      wr_reg(A_CFG, 8'h80);
      @(posedge clk);
      osc_resume <= 1'b1;
      @(posedge clk);
      osc_resume <= 1'b0;
      #1;
      chk1(ext_irq1_active, 1'b0, "resume, gate on");
      test_done();
   end
endmodule
